// [dv/xcbt_ate_model.sv]
`timescale 1ns/1ps
`default_nettype none
module xcbt_ate_model (
  input  wire logic core_clk,
  output wire logic sideband_addr_strap_a,
  output wire logic sideband_addr_strap_b,
  output wire logic test_enable_in_n,
  output wire logic power_good_in,
  output wire logic reset_in_n,
  output wire logic host_clock_pos,
  output wire logic host_clock_neg
);
  logic [4:0] pins = 5'h1c;
  logic       hclk = 1'b0;
  // Host clock pair runs only while power good is driven high
  always @(posedge core_clk) hclk <= pins[1] & ~hclk;
  assign host_clock_pos = hclk;
  assign host_clock_neg = ~hclk;
  assign {sideband_addr_strap_a, sideband_addr_strap_b, test_enable_in_n, power_good_in,
    reset_in_n} = pins;
  task automatic step(input logic [4:0] v);
    @(posedge core_clk) pins <= v;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic enter();
    step(5'h00);
    step(5'h02);
    step(5'h03);
    step(5'h1b);
  endtask
endmodule // xcbt_ate_model
`default_nettype wire

// [dv/xcbt_props.sv]
`timescale 1ns/1ps
`default_nettype none
module xcbt_props #(parameter CHAIN_W = 60) (
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire logic                  reset_in_n,
  input wire logic [1:0]            channel_mode,
  input wire logic [59:0]           chain0_pins,
  input wire logic [11*CHAIN_W-1:0] chain_pins,
  input wire logic                  test_mode_active,
  input wire logic [7:0]            test_out_chan_a,
  input wire logic [7:0]            test_out_chan_b,
  input wire logic                  host_target_ready_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire [7:0] ta = test_out_chan_a;
  wire [7:0] tb = test_out_chan_b;
  wire       m  = test_mode_active;
  wire       p0 = ^chain0_pins;
  wire       p8 = ^chain_pins[7*CHAIN_W +: CHAIN_W];
  sequence s_full;
    m && channel_mode[0] == channel_mode[1];
  endsequence
  sequence s_one_flip;
    $countones(chain0_pins ^ $past(chain0_pins)) == 1;
  endsequence
  property p_flip;
    s_full ##1 (s_full and s_one_flip)
      |-> ta[0] != $past(ta[0]);
  endproperty
  chk_a0_par: assert property (s_full |-> ta[0] == p0)
    else $error("chain 0 wrong");
  chk_ab_same: assert property (s_full |-> ta == tb)
    else $error("channels differ");
  chk_a_only: assert property (m && channel_mode == 2'h1 |-> tb == 8'hff)
    else $error("b shown");
  chk_b_only: assert property (m && channel_mode == 2'h2 |-> ta == 8'hff && tb[0] == p0)
    else $error("a shown");
  chk_idle_high: assert property (!m |-> ta == 8'hff && tb == 8'hff)
    else $error("idle not high");
  chk_reset_exit: assert property (!reset_in_n [*8] |-> !m)
    else $error("mode held");
  chk_host_par: assert property (s_full |-> host_target_ready_n == p8)
    else $error("host pin wrong");
  chk_flip_inv: assert property (p_flip)
    else $error("no inversion");
endmodule // xcbt_props
bind xcbt_top xcbt_props #(.CHAIN_W(CHAIN_W)) u_props (.core_clk, .rst, .reset_in_n,
  .channel_mode, .chain0_pins, .chain_pins, .test_mode_active, .test_out_chan_a,
  .test_out_chan_b, .host_target_ready_n);
`default_nettype wire

// [dv/xor_chain_board_test_test.sv]
`timescale 1ns/1ps
`default_nettype none
module xor_chain_board_test_test;
  logic         core_clk = '0;
  logic         rst = '1;
  logic [1:0]   channel_mode = '0;
  logic [59:0]  chain0_pins = '0;
  logic [659:0] chain_pins = '0;
  wire          sideband_addr_strap_a, sideband_addr_strap_b, test_enable_in_n;
  wire          power_good_in, reset_in_n, test_mode_active;
  wire  [7:0]   test_out_chan_a, test_out_chan_b, ho;
  int           n_mismatch = 0;
  int           tests_run = 0;
  always #25 core_clk = ~core_clk;
  xcbt_ate_model ate (.core_clk, .sideband_addr_strap_a, .sideband_addr_strap_b,
    .test_enable_in_n, .power_good_in, .reset_in_n, .host_clock_pos(), .host_clock_neg());
  xcbt_top dut (.core_clk, .rst, .sideband_addr_strap_a, .sideband_addr_strap_b,
    .test_enable_in_n, .power_good_in, .reset_in_n, .channel_mode, .chain0_pins,
    .chain_pins, .test_mode_active, .test_out_chan_a, .test_out_chan_b,
    .host_target_ready_n(ho[7]), .host_priority_request_n(ho[6]),
    .host_response_bit2_n(ho[5]), .host_n_a(ho[4]), .host_response_bit0_n(ho[3]),
    .host_response_bit1_n(ho[2]), .host_bus_request0_n(ho[1]), .processor_reset_n(ho[0]));
  function automatic logic par(int k);
    return k == 0 ? ^chain0_pins : ^chain_pins[(k-1)*60 +: 60];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_all(input logic on);
    logic [7:0] e, h;
    logic       sa, sb;
    #1;
    for (int k = 0; k < 8; k++) e[k] = par(k);
    for (int k = 0; k < 4; k++) h[7-2*k -: 2] = {2{par(8+k)}};
    sa = on && channel_mode != 2'h2;
    sb = on && channel_mode != 2'h1;
    chk(test_out_chan_a, sa ? e : 8'hff);
    chk(test_out_chan_b, sb ? e : 8'hff);
    chk(ho, h | {4{~sa, ~sb}});
    chk({7'h0, test_mode_active}, {7'h0, on});
  endtask
  task automatic t_refuse();
    ate.step(5'h00);
    ate.step(5'h01);
    ate.step(5'h03);
    cmp_all(1'h0);
  endtask
  task automatic t_enter();
    ate.enter();
    cmp_all(1'h1);
  endtask
  task automatic t_flips();
    for (int i = 0; i < 60; i++) begin
      @(posedge core_clk) chain0_pins[i] <= ~chain0_pins[i];
      cmp_all(1'h1);
      @(posedge core_clk) chain_pins[i*11] <= ~chain_pins[i*11];
      cmp_all(1'h1);
    end
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk) channel_mode <= m[1:0];
      cmp_all(1'h1);
    end
  endtask
  task automatic t_exit();
    ate.step(5'h1a);
    cmp_all(1'h0);
  endtask
  task automatic end_sim();
    $display("runs=%0d bad=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    t_refuse();
    t_enter();
    t_flips();
    t_modes();
    t_exit();
    end_sim();
  end
  initial begin
    repeat (1000) @(posedge core_clk);
    n_mismatch++;
    end_sim();
  end
endmodule // xor_chain_board_test_test
`default_nettype wire

// [rtl/xcbt_map.vh]
`ifndef XCBT_MAP_VH
`define XCBT_MAP_VH
// Chain geometry
`define XCBT_NUM_CHAINS 12
`define XCBT_NUM_TEST_CHAINS 10
`define XCBT_CHAIN0_WIDTH 60
`define XCBT_CHAIN_MAX_WIDTH 60
`define XCBT_NUM_TESTP_CHAINS 8
// Channel select encodings
`define XCBT_MODE_FULL 2'h0
`define XCBT_MODE_CHAN_A 2'h1
`define XCBT_MODE_CHAN_B 2'h2
// Entry sequence states
`define XCBT_ST_IDLE 4'h1
`define XCBT_ST_ARMED 4'h2
`define XCBT_ST_PWR 4'h4
`define XCBT_ST_TEST 4'h8
// Synchroniser depth
`define XCBT_SYNC_STAGES 3
`endif

// [rtl/xcbt_parity_chain.v]
`timescale 1ns/1ps
`default_nettype none
module xcbt_parity_chain #(
  parameter WIDTH = 60
) (
  input  wire [WIDTH-1:0] pins,
  output wire             result
);
  wire [WIDTH:0] stage;
  assign stage[0] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_gate
      // One pin per gate
      assign stage[i+1] = stage[i] ^ pins[i];
    end
  endgenerate
  assign result = stage[WIDTH];
endmodule // xcbt_parity_chain
`default_nettype wire

// [rtl/xcbt_top.v]
// Summary of operation
// - Each chain XORs one pin per gate.
// - Chains propagate combinationally with no clock.
// - Outputs valid only after reset-in released.
// - Graphics strobes split across chains; others together.
// - Twelve chains, each on two channel pins.
// - Chains 0-7 on test pins, 8-11 host pins.
// - Full width: same result on both channels.
// - Shared mode: only active channel pin shows result.
// - Chain 0 folds sixty inputs.
`timescale 1ns/1ps
`default_nettype none
`include "xcbt_map.vh"
module xcbt_top #(
  parameter CHAIN_W = `XCBT_CHAIN_MAX_WIDTH
) (
  input  wire                                   core_clk,
  input  wire                                   rst,
  input  wire                                   sideband_addr_strap_a,
  input  wire                                   sideband_addr_strap_b,
  input  wire                                   test_enable_in_n,
  input  wire                                   power_good_in,
  input  wire                                   reset_in_n,
  input  wire [1:0]                             channel_mode,
  input  wire [`XCBT_CHAIN0_WIDTH-1:0]          chain0_pins,
  input  wire [(`XCBT_NUM_CHAINS-1)*CHAIN_W-1:0] chain_pins,
  output wire                                   test_mode_active,
  output wire [`XCBT_NUM_TESTP_CHAINS-1:0]      test_out_chan_a,
  output wire [`XCBT_NUM_TESTP_CHAINS-1:0]      test_out_chan_b,
  output wire                                   host_target_ready_n,
  output wire                                   host_priority_request_n,
  output wire                                   host_response_bit2_n,
  output wire                                   host_n_a,
  output wire                                   host_response_bit0_n,
  output wire                                   host_response_bit1_n,
  output wire                                   host_bus_request0_n,
  output wire                                   processor_reset_n
);
  localparam ST_IDLE  = `XCBT_ST_IDLE;
  localparam ST_ARMED = `XCBT_ST_ARMED;
  localparam ST_PWR   = `XCBT_ST_PWR;
  localparam ST_TEST  = `XCBT_ST_TEST;
  localparam MODE_FULL   = `XCBT_MODE_FULL;
  localparam MODE_CHAN_A = `XCBT_MODE_CHAN_A;
  localparam MODE_CHAN_B = `XCBT_MODE_CHAN_B;

  // Pin synchronisers: three stages, change accepted when last two agree
  // Straps and test enable start high, matching their idle level
  reg [2:0] sync_pg;
  reg [2:0] sync_rst_in;
  reg [2:0] sync_test;
  reg [2:0] sync_sa;
  reg [2:0] sync_sb;
  reg       pg;
  reg       rin;
  reg       ten;
  reg       sa;
  reg       sb;
  always @(posedge core_clk) begin
    if (rst) begin
      sync_pg     <= 3'h0;
      sync_rst_in <= 3'h0;
      sync_test   <= 3'h7;
      sync_sa     <= 3'h7;
      sync_sb     <= 3'h7;
      pg          <= 1'b0;
      rin         <= 1'b0;
      ten         <= 1'b1;
      sa          <= 1'b1;
      sb          <= 1'b1;
    end else begin
      sync_pg     <= {sync_pg[1:0], power_good_in};
      sync_rst_in <= {sync_rst_in[1:0], reset_in_n};
      sync_test   <= {sync_test[1:0], test_enable_in_n};
      sync_sa     <= {sync_sa[1:0], sideband_addr_strap_a};
      sync_sb     <= {sync_sb[1:0], sideband_addr_strap_b};
      if (sync_pg[1] == sync_pg[2])
        pg <= sync_pg[2];
      if (sync_rst_in[1] == sync_rst_in[2])
        rin <= sync_rst_in[2];
      if (sync_test[1] == sync_test[2])
        ten <= sync_test[2];
      if (sync_sa[1] == sync_sa[2])
        sa <= sync_sa[2];
      if (sync_sb[1] == sync_sb[2])
        sb <= sync_sb[2];
    end
  end

  // Entry sequence: all low, then power good, then reset-in
  reg [3:0] state;
  reg [3:0] next_state;
  // Entry needs every strap and control low before power good rises
  wire      straps_low = ~sa & ~sb;
  wire      test_on    = ~ten;
  wire      ctrl_low   = ~pg & ~rin;
  wire      all_low    = straps_low & test_on & ctrl_low;
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        // Wait for every strap and control pin to read low
        if (all_low)
          next_state = ST_ARMED;
      end
      ST_ARMED: begin
        // Reset-in ahead of power good breaks the order
        if (rin)
          next_state = ST_IDLE;
        else if (pg)
          next_state = ST_PWR;
        else if (ten)
          next_state = ST_IDLE;
      end
      ST_PWR: begin
        // Test enable raised late breaks the order
        if (~pg | ten)
          next_state = ST_IDLE;
        else if (rin)
          next_state = ST_TEST;
      end
      ST_TEST: begin
        // Straps may move once in test; only power or reset-in end it
        if (~pg | ~rin)
          next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end
  always @(posedge core_clk) begin
    if (rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end
  // Registered so the mode flag never glitches while the state decodes
  reg       test_mode;
  always @(posedge core_clk) begin
    if (rst)
      test_mode <= 1'b0;
    else
      test_mode <= (next_state == ST_TEST);
  end
  assign test_mode_active = test_mode;

  // Chains: combinational, no clock in the data path
  // Chains 1 to 11 take the widest width, CHAIN_W pins each from chain_pins
  // Chain 0 has its own width of sixty pins
  wire [`XCBT_NUM_CHAINS-1:0] result;
  xcbt_parity_chain #(
    .WIDTH (`XCBT_CHAIN0_WIDTH)
  ) u_chain0 (
    .pins   (chain0_pins),
    .result (result[0])
  );
  genvar c;
  generate
    for (c = 1; c < `XCBT_NUM_CHAINS; c = c + 1) begin : g_chain
      xcbt_parity_chain #(
        .WIDTH (CHAIN_W)
      ) u_chain (
        .pins   (chain_pins[(c-1)*CHAIN_W +: CHAIN_W]),
        .result (result[c])
      );
    end
  endgenerate

  // Channel steering; idle pins hold high outside test mode
  // High idle keeps an unshown pin from passing for a result
  reg                         show_a;
  reg                         show_b;
  always @* begin
    show_a = 1'b0;
    show_b = 1'b0;
    if (test_mode_active) begin
      case (channel_mode)
        MODE_FULL: begin
          show_a = 1'b1;
          show_b = 1'b1;
        end
        MODE_CHAN_A: begin
          show_a = 1'b1;
        end
        MODE_CHAN_B: begin
          show_b = 1'b1;
        end
        default: begin
          // Code three shows both channels
          show_a = 1'b1;
          show_b = 1'b1;
        end
      endcase
    end
  end
  wire [`XCBT_NUM_CHAINS-1:0] out_a;
  wire [`XCBT_NUM_CHAINS-1:0] out_b;
  // One steering pair per chain, idle high
  genvar k;
  generate
    for (k = 0; k < `XCBT_NUM_CHAINS; k = k + 1) begin : g_steer
      assign out_a[k] = show_a ? result[k] : 1'b1;
      assign out_b[k] = show_b ? result[k] : 1'b1;
    end
  endgenerate

  assign test_out_chan_a         = out_a[`XCBT_NUM_TESTP_CHAINS-1:0];
  assign test_out_chan_b         = out_b[`XCBT_NUM_TESTP_CHAINS-1:0];
  // Chains 8 to 11 use host control pin pairs
  assign host_target_ready_n     = out_a[8];
  assign host_priority_request_n = out_b[8];
  assign host_response_bit2_n    = out_a[9];
  assign host_n_a                = out_b[9];
  assign host_response_bit0_n    = out_a[10];
  assign host_response_bit1_n    = out_b[10];
  assign host_bus_request0_n     = out_a[11];
  assign processor_reset_n       = out_b[11];
endmodule // xcbt_top
`default_nettype wire
